// File: inc/uem_map.vh
`ifndef UEM_MAP_VH
`define UEM_MAP_VH
// Register offsets.
`define UEM_CNT0_OFS     8'h11
`define UEM_MODE0_OFS    8'h12
`define UEM_CNT1_OFS     8'h13
`define UEM_MODE1_OFS    8'h14
`define UEM_CNT2_OFS     8'h15
`define UEM_MODE2_OFS    8'h16
`define UEM_CNT3_OFS     8'h41
`define UEM_MODE3_OFS    8'h42
`define UEM_CNT4_OFS     8'h43
`define UEM_MODE4_OFS    8'h44
// Field positions.
`define UEM_MODE_LSB     0
`define UEM_MODE_MSB     3
`define UEM_ACK_BIT      4
`define UEM_OUTST_BIT    5
`define UEM_INST_BIT     6
`define UEM_SETUP_BIT    7
`define UEM_STALL_BIT    7
`define UEM_BC_MSB       5
`define UEM_DVAL_BIT     6
`define UEM_TOG_BIT      7
// Reset values.
`define UEM_MODE_RST     8'h00
`define UEM_CNT_RST      8'h00
// Mode codes.
`define UEM_M_DISABLED   4'h0
`define UEM_M_NAK_IO     4'h1
`define UEM_M_STALL_IO   4'h3
`define UEM_M_IGN_IO     4'h4
`define UEM_M_STS_IN     4'h6
`define UEM_M_NAK_OUT    4'h8
`define UEM_M_ACK_OUT    4'h9
`define UEM_M_CW_NAK     4'ha
`define UEM_M_CW_OUT     4'hb
`define UEM_M_NAK_IN     4'hc
`define UEM_M_ACK_IN     4'hd
`define UEM_M_ACK_OUT_K  4'he
`define UEM_M_CR_IN      4'hf
// Token identifiers.
`define UEM_PID_OUT      2'h0
`define UEM_PID_IN       2'h1
`define UEM_PID_SETUP    2'h2
// Responses.
`define UEM_R_IGNORE     3'h0
`define UEM_R_ACK        3'h1
`define UEM_R_NAK        3'h2
`define UEM_R_STALL      3'h3
`define UEM_R_TXDATA     3'h4
// Limits.
`define UEM_CTRL_MAXCNT  6'h0a
`define UEM_CRC_BYTES    6'h02
`define UEM_EP0_SIZE     6'h08
`define UEM_EPN_SIZE     6'h20
`endif

// File: verilog/uem_endpoint_engine.v
// Operation
// [RULE_01] Low four mode bits choose how each endpoint answers traffic.
// [RULE_02] Acknowledge bit 4 sets when a transaction ends with ACK.
// [RULE_03] Firmware loads byte count 0 to 32 for IN transmissions.
// [RULE_04] After OUT or SETUP, count becomes received bytes plus two.
// [RULE_05] Data valid set on good CRC; bad CRC clears it, still interrupts.
// [RULE_06] Bit 7 is the packet toggle; hardware copies it on OUT or SETUP.
// [RULE_07] Stall bit stalls OUT in ACK-IN and IN in ACK-OUT modes.
// [RULE_08] Endpoint 0 counter locks after OUT or SETUP update until read.
// [RULE_09] SETUP forces endpoint 0 setup bit high until data phase ends.
// [RULE_10] Lock releases only for a CPU read after the update point.
// [RULE_11] Update point refreshes mode, counter and endpoint interrupt flag.
// [RULE_12] Endpoints reset disabled; disabled ones ignore all tokens.
// [RULE_13] Valid SETUP in accepting mode gets ACK and mode 0001.
// [RULE_14] ACKed transactions move to NAKing mode except 1010 and 1110; here an ACKed IN in 0110, 1011 or 1111 keeps its mode too.
// [RULE_15] Invalid transactions ignored; interrupt on completion or corruption.
// [RULE_16] Data packet valid only when checks pass and length fits.
// [RULE_17] OUT endpoints ignore IN tokens and IN endpoints ignore OUT.
// [RULE_18] IN and OUT status at end; SETUP status at data start.
// [RULE_19] Firmware reads mode, checks setup bit, before writing it.
// [RULE_20] Control modes ignore long OUT data, answer IN with empty packet; here mode 1111 on endpoint 0 and endpoints 1-4 send the loaded count.
// [RULE_21] Control endpoint has SETUP, IN and OUT token status bits.
// [RULE_22] Interrupt on the last packet; none when an IN gets no ACK.
//
// Chosen here: the plain strobed port.
`include "uem_map.vh"
`timescale 1ns/10ps
`default_nettype none
module uem_endpoint_engine #(
  parameter [5:0] EP0_SIZE = `UEM_EP0_SIZE,
  parameter [5:0] EPN_SIZE = `UEM_EPN_SIZE
) (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       arst_n,
  // Register port.
  input  wire [7:0] cpu_addr,
  input  wire [7:0] cpu_wdata,
  input  wire       cpu_wr,
  input  wire       cpu_rd,
  output reg  [7:0] cpu_rdata_q,
  // Token and packet events from the serial interface engine.
  input  wire       tok_stb,
  input  wire [1:0] tok_pid,
  input  wire [2:0] tok_ep,
  input  wire       tok_addr_ok,
  input  wire       pkt_stb,
  input  wire [5:0] pkt_count,
  input  wire       pkt_toggle,
  input  wire       pkt_crc_ok,
  input  wire       pkt_err_ok,
  input  wire       hs_ack_stb,
  input  wire       hs_timeout_stb,
  // Response to the serial interface engine.
  output reg        resp_stb_q,
  output reg  [2:0] resp_code_q,
  output reg  [5:0] resp_count_q,
  output reg        resp_toggle_q,
  // Endpoint interrupt flags, one-cycle pulses.
  output reg  [4:0] ep_int_q
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DATA = 2'd1;
  localparam [1:0] ST_HS   = 2'd2;

  reg [7:0] mode_q [0:4];
  reg [7:0] cnt_q  [0:4];
  reg [1:0] st_q;
  reg [2:0] ep_q;
  reg [1:0] pid_q;
  reg       lock_q;
  reg       setup_force_q;
  reg [3:0] hs_mode_q;
  reg       hs_mode_chg_q;
  reg       hs_ack_q;
  reg       hs_in_q;

  // Register address to endpoint index; 7 means unmapped.
  function [2:0] reg_ep;
    input [7:0] a;
    begin
      case (a)
        `UEM_CNT0_OFS, `UEM_MODE0_OFS: reg_ep = 3'd0;
        `UEM_CNT1_OFS, `UEM_MODE1_OFS: reg_ep = 3'd1;
        `UEM_CNT2_OFS, `UEM_MODE2_OFS: reg_ep = 3'd2;
        `UEM_CNT3_OFS, `UEM_MODE3_OFS: reg_ep = 3'd3;
        `UEM_CNT4_OFS, `UEM_MODE4_OFS: reg_ep = 3'd4;
        default: reg_ep = 3'd7;
      endcase
    end
  endfunction

  function is_mode_reg;
    input [7:0] a;
    begin
      is_mode_reg = (a == `UEM_MODE0_OFS) || (a == `UEM_MODE1_OFS) ||
                    (a == `UEM_MODE2_OFS) || (a == `UEM_MODE3_OFS) ||
                    (a == `UEM_MODE4_OFS);
    end
  endfunction

  wire [2:0] cur_ep   = (st_q == ST_IDLE) ? tok_ep : ep_q;
  wire       ep_ok    = (cur_ep <= 3'd4);
  wire [2:0] ep_idx   = ep_ok ? cur_ep : 3'd0;
  wire [7:0] cur_mreg = mode_q[ep_idx];
  wire [3:0] cur_mode = cur_mreg[`UEM_MODE_MSB:`UEM_MODE_LSB]; // RULE_01
  wire       cur_stall = (ep_idx != 3'd0) && cur_mreg[`UEM_STALL_BIT];
  wire [5:0] ep_size  = (ep_idx == 3'd0) ? EP0_SIZE : EPN_SIZE;
  wire       len_ok   = (pkt_count <= ep_size + `UEM_CRC_BYTES); // RULE_16
  wire       good     = pkt_crc_ok && pkt_err_ok && len_ok; // RULE_16
  wire       short_ok = (pkt_count <= `UEM_CTRL_MAXCNT);
  wire       ctl_mode = (cur_mode == `UEM_M_CW_OUT) ||
                        (cur_mode == `UEM_M_CW_NAK) ||
                        (cur_mode == `UEM_M_STS_IN) ||
                        (cur_mode == `UEM_M_CR_IN);
  wire       setup_acc = (ep_idx == 3'd0) && (ctl_mode ||
                         (cur_mode == `UEM_M_NAK_IO) ||
                         (cur_mode == `UEM_M_STALL_IO));

  // Decision of the current event.
  reg       d_go;
  reg [2:0] d_resp;
  reg       d_wait_hs;
  reg       d_mode_chg;
  reg [3:0] d_mode;
  reg       d_ack;
  reg       d_in;
  reg       d_out;
  reg       d_cnt_upd;
  reg       d_dval;
  reg       d_irq;

  always @* begin
    d_go       = 1'b0;
    d_resp     = `UEM_R_IGNORE;
    d_wait_hs  = 1'b0;
    d_mode_chg = 1'b0;
    d_mode     = cur_mode;
    d_ack      = 1'b0;
    d_in       = 1'b0;
    d_out      = 1'b0;
    d_cnt_upd  = 1'b0;
    d_dval     = 1'b0;
    d_irq      = 1'b0;
    if (st_q == ST_IDLE && tok_stb && tok_addr_ok && ep_ok &&
        tok_pid == `UEM_PID_IN) begin // RULE_15
      d_go = 1'b1;
      case (cur_mode) // RULE_12 RULE_17
        `UEM_M_NAK_IO, `UEM_M_NAK_IN: begin
          d_resp = `UEM_R_NAK;
          d_in   = 1'b1;
          d_irq  = 1'b1;
        end
        `UEM_M_STALL_IO: begin
          d_resp = `UEM_R_STALL;
          d_in   = 1'b1;
          d_irq  = 1'b1;
        end
        `UEM_M_ACK_OUT, `UEM_M_ACK_OUT_K: begin
          if (cur_stall) begin // RULE_07
            d_resp = `UEM_R_STALL;
            d_irq  = 1'b1;
          end
        end
        `UEM_M_ACK_IN: begin
          d_resp     = cur_stall ? `UEM_R_STALL : `UEM_R_TXDATA;
          d_wait_hs  = !cur_stall;
          d_mode_chg = !cur_stall; // RULE_14
          d_mode     = `UEM_M_NAK_IN;
          d_irq      = cur_stall;
        end
        `UEM_M_CW_OUT, `UEM_M_CW_NAK, `UEM_M_STS_IN,
        `UEM_M_CR_IN: begin
          // On endpoint 0 only the read data stage sends a payload; the others send empty.
          d_resp    = `UEM_R_TXDATA; // RULE_20
          d_wait_hs = 1'b1;
          d_in      = 1'b1; // RULE_21
        end
        default: d_go = 1'b0;
      endcase
    end else if (st_q == ST_DATA && pkt_stb) begin
      d_go = 1'b1;
      if (pid_q == `UEM_PID_SETUP) begin
        d_cnt_upd = 1'b1; // RULE_04
        d_irq     = 1'b1;
        if (good && short_ok) begin // RULE_13
          d_resp     = `UEM_R_ACK;
          d_mode_chg = 1'b1;
          d_mode     = `UEM_M_NAK_IO;
          d_ack      = 1'b1;
          d_dval     = 1'b1;
        end
      end else begin
        case (cur_mode)
          `UEM_M_NAK_IO: begin
            d_resp = `UEM_R_NAK;
            d_out  = 1'b1;
            d_irq  = 1'b1;
          end
          `UEM_M_STALL_IO: begin
            d_resp = `UEM_R_STALL;
            d_out  = 1'b1;
            d_irq  = 1'b1;
          end
          `UEM_M_ACK_IN: begin
            if (cur_stall) begin // RULE_07
              d_resp = `UEM_R_STALL;
              d_irq  = 1'b1;
            end
          end
          `UEM_M_NAK_OUT: begin
            d_resp = good ? `UEM_R_NAK : `UEM_R_IGNORE;
            d_irq  = good;
          end
          `UEM_M_ACK_OUT, `UEM_M_ACK_OUT_K: begin
            if (cur_stall) begin
              d_resp = `UEM_R_STALL;
              d_irq  = 1'b1;
            end else begin
              d_cnt_upd = 1'b1;
              d_irq     = 1'b1; // RULE_15
              if (good) begin // RULE_05
                d_resp     = `UEM_R_ACK;
                d_dval     = 1'b1;
                d_ack      = 1'b1;
                d_mode_chg = (cur_mode == `UEM_M_ACK_OUT); // RULE_14
                d_mode     = `UEM_M_NAK_OUT;
              end
            end
          end
          `UEM_M_CW_OUT: begin
            d_cnt_upd = 1'b1;
            d_out     = 1'b1;
            d_irq     = 1'b1;
            if (good && short_ok) begin
              d_resp     = `UEM_R_ACK;
              d_dval     = 1'b1;
              d_ack      = 1'b1;
              d_mode_chg = 1'b1;
              d_mode     = `UEM_M_CW_NAK;
            end
          end
          `UEM_M_CW_NAK: begin
            if (good && short_ok) begin // RULE_20
              d_resp = `UEM_R_NAK;
              d_out  = 1'b1;
              d_irq  = 1'b1;
            end
          end
          `UEM_M_STS_IN, `UEM_M_CR_IN: begin
            if (good && short_ok) begin
              d_resp     = `UEM_R_STALL;
              d_out      = 1'b1;
              d_irq      = 1'b1;
              d_mode_chg = 1'b1;
              d_mode     = `UEM_M_STALL_IO;
              d_cnt_upd  = (cur_mode == `UEM_M_CR_IN);
              d_dval     = 1'b1;
            end
          end
          default: d_go = 1'b0;
        endcase
      end
    end
  end

  // Update point: immediate decisions or the host ACK of an IN payload.
  wire       hs_done = (st_q == ST_HS) && hs_ack_stb; // RULE_22
  wire       upd     = (d_go && !d_wait_hs) || hs_done;
  wire       u_mchg  = hs_done ? hs_mode_chg_q : d_mode_chg;
  wire [3:0] u_mode  = hs_done ? hs_mode_q : d_mode;
  wire       u_ack   = hs_done ? hs_ack_q : d_ack;
  wire       u_in    = hs_done ? hs_in_q : d_in;
  wire       u_irq   = hs_done ? 1'b1 : d_irq;
  wire       u_cnt   = hs_done ? 1'b0 : d_cnt_upd;
  wire       u_lock  = (ep_idx == 3'd0) && (u_cnt || u_ack);
  wire       tok_setup = (st_q == ST_IDLE) && tok_stb && tok_addr_ok &&
                         (tok_pid == `UEM_PID_SETUP) && setup_acc;
  wire [2:0] w_ep    = reg_ep(cpu_addr);
  wire       w_mode  = is_mode_reg(cpu_addr);
  wire [2:0] r_ep    = reg_ep(cpu_addr);

  integer i;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 5; i = i + 1) begin
        mode_q[i] <= `UEM_MODE_RST; // RULE_12
        cnt_q[i]  <= `UEM_CNT_RST;
      end
      st_q          <= ST_IDLE;
      ep_q          <= 3'd0;
      pid_q         <= `UEM_PID_OUT;
      lock_q        <= 1'b0;
      setup_force_q <= 1'b0;
      hs_mode_q     <= `UEM_M_DISABLED;
      hs_mode_chg_q <= 1'b0;
      hs_ack_q      <= 1'b0;
      hs_in_q       <= 1'b0;
      cpu_rdata_q   <= 8'h00;
      resp_stb_q    <= 1'b0;
      resp_code_q   <= `UEM_R_IGNORE;
      resp_count_q  <= 6'h00;
      resp_toggle_q <= 1'b0;
      ep_int_q      <= 5'h00;
    end else begin
      // Firmware writes first so that a same-cycle hardware update wins.
      if (cpu_wr && w_ep != 3'd7) begin
        if (w_mode) begin
          if (w_ep != 3'd0 || !lock_q) begin
            mode_q[w_ep][6:0] <= cpu_wdata[6:0];
          end
          if (w_ep != 3'd0 || !setup_force_q) begin // RULE_09
            mode_q[w_ep][7] <= cpu_wdata[7];
          end
        end else if (w_ep != 3'd0 || !lock_q) begin // RULE_08
          cnt_q[w_ep] <= cpu_wdata; // RULE_03 RULE_06
        end
      end
      cpu_rdata_q <= 8'h00;
      if (cpu_rd && r_ep != 3'd7) begin
        cpu_rdata_q <= is_mode_reg(cpu_addr) ? mode_q[r_ep] : cnt_q[r_ep];
      end
      // A read in the update cycle itself does not release the lock.
      if (u_lock && upd) begin
        lock_q <= 1'b1; // RULE_08
      end else if (cpu_rd && r_ep == 3'd0) begin
        lock_q <= 1'b0; // RULE_10 RULE_19
      end
      if (tok_setup) begin
        mode_q[0][`UEM_SETUP_BIT] <= 1'b1; // RULE_09 RULE_18 RULE_21
        setup_force_q <= 1'b1;
      end
      resp_stb_q <= 1'b0;
      ep_int_q   <= 5'h00;
      // An ignored event keeps the link silent though state may update.
      if (d_go && d_resp != `UEM_R_IGNORE) begin // RULE_17
        resp_stb_q    <= 1'b1;
        resp_code_q   <= d_resp;
        resp_count_q  <= (d_resp == `UEM_R_TXDATA &&
                          (ep_idx != 3'd0 || cur_mode == `UEM_M_CR_IN)) ?
                         cnt_q[ep_idx][`UEM_BC_MSB:0] : 6'h00; // RULE_20
        resp_toggle_q <= cnt_q[ep_idx][`UEM_TOG_BIT];
      end
      if (upd) begin // RULE_11
        if (u_mchg) begin
          mode_q[ep_idx][`UEM_MODE_MSB:`UEM_MODE_LSB] <= u_mode; // RULE_14
        end
        if (u_ack) begin
          mode_q[ep_idx][`UEM_ACK_BIT] <= 1'b1; // RULE_02
        end
        if (ep_idx == 3'd0 && u_in) begin
          mode_q[0][`UEM_INST_BIT] <= 1'b1; // RULE_18
        end
        if (ep_idx == 3'd0 && !hs_done && d_out) begin
          mode_q[0][`UEM_OUTST_BIT] <= 1'b1; // RULE_18
        end
        if (u_cnt) begin
          cnt_q[ep_idx][`UEM_BC_MSB:0] <= pkt_count; // RULE_04
          cnt_q[ep_idx][`UEM_DVAL_BIT] <= d_dval; // RULE_05
          cnt_q[ep_idx][`UEM_TOG_BIT]  <= pkt_toggle; // RULE_06
        end
        if (u_irq) begin
          ep_int_q[ep_idx] <= 1'b1; // RULE_15 RULE_22
        end
        if (!hs_done && pid_q == `UEM_PID_SETUP && st_q == ST_DATA) begin
          setup_force_q <= 1'b0;
        end
      end
      case (st_q)
        ST_IDLE: begin
          if (tok_stb && tok_addr_ok && ep_ok) begin
            ep_q  <= tok_ep;
            pid_q <= tok_pid;
            if (tok_pid == `UEM_PID_OUT || tok_setup) begin
              st_q <= ST_DATA;
            end else if (d_go && d_wait_hs) begin
              st_q          <= ST_HS;
              hs_mode_q     <= d_mode;
              hs_mode_chg_q <= d_mode_chg;
              hs_ack_q      <= 1'b1;
              hs_in_q       <= d_in;
            end
          end
        end
        ST_DATA: begin
          if (pkt_stb) begin
            st_q <= ST_IDLE;
          end
        end
        ST_HS: begin
          if (hs_ack_stb || hs_timeout_stb) begin
            st_q <= ST_IDLE; // RULE_22
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // uem_endpoint_engine
`default_nettype wire

// File: dv/uem_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module uem_host_model (
  // Clock.
  input  wire logic       core_clk,
  // Token fields.
  output var  logic       tok_stb,
  output var  logic [1:0] tok_pid,
  output var  logic [2:0] tok_ep,
  output var  logic       tok_addr_ok,
  // Data packet fields.
  output var  logic       pkt_stb,
  output var  logic [5:0] pkt_count,
  output var  logic       pkt_toggle,
  output var  logic       pkt_crc_ok,
  output var  logic       pkt_err_ok,
  // Handshake from the host.
  output var  logic       hs_ack_stb,
  output var  logic       hs_timeout_stb
);
  initial begin
    {tok_stb, tok_pid, tok_ep, tok_addr_ok} = 7'h00;
    {pkt_stb, pkt_count, pkt_toggle, pkt_crc_ok, pkt_err_ok} = 10'h000;
    {hs_ack_stb, hs_timeout_stb} = 2'h0;
  end

  // Released qualifiers flip so that a stale value is never mistaken.
  task token(input logic [1:0] p, input logic [2:0] e, input logic ok);
    tok_stb <= 1'b1;
    tok_pid <= p;
    tok_ep <= e;
    tok_addr_ok <= ok;
    @(posedge core_clk);
    tok_stb <= 1'b0;
    tok_pid <= ~p;
    tok_ep <= ~e;
    tok_addr_ok <= ~ok;
  endtask

  task packet(input logic [5:0] c, input logic t, input logic crc);
    pkt_stb <= 1'b1;
    pkt_count <= c;
    pkt_toggle <= t;
    pkt_crc_ok <= crc;
    pkt_err_ok <= 1'b1;
    @(posedge core_clk);
    pkt_stb <= 1'b0;
    pkt_count <= ~c;
    pkt_toggle <= ~t;
    pkt_crc_ok <= ~crc;
    pkt_err_ok <= 1'b0;
  endtask

  task hs(input logic ack);
    hs_ack_stb <= ack;
    hs_timeout_stb <= ~ack;
    @(posedge core_clk);
    hs_ack_stb <= 1'b0;
    hs_timeout_stb <= 1'b0;
  endtask
endmodule // uem_host_model
`default_nettype wire

// File: dv/uem_checker_assertions.sv
`include "uem_map.vh"
`timescale 1ns/10ps
`default_nettype none
module uem_checker (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Register port.
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_rdata_q,
  // Link events.
  input wire logic       tok_stb,
  input wire logic [1:0] tok_pid,
  input wire logic [2:0] tok_ep,
  input wire logic       tok_addr_ok,
  input wire logic       pkt_stb,
  input wire logic [5:0] pkt_count,
  input wire logic       pkt_toggle,
  input wire logic       pkt_crc_ok,
  input wire logic       pkt_err_ok,
  input wire logic       hs_ack_stb,
  input wire logic       hs_timeout_stb,
  // Responses.
  input wire logic       resp_stb_q,
  input wire logic [2:0] resp_code_q,
  input wire logic [5:0] resp_count_q,
  input wire logic       resp_toggle_q,
  input wire logic [4:0] ep_int_q
);
  logic [2:0] last_ep_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) last_ep_q <= 3'h0;
    else if (tok_stb) last_ep_q <= tok_ep;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_in_sent;
    resp_stb_q && resp_code_q == `UEM_R_TXDATA;
  endsequence
  sequence s_host_ack;
    hs_ack_stb;
  endsequence

  a_resp_cause: assert property (
    resp_stb_q |-> $past(tok_stb) || $past(pkt_stb))
    else $error("response without a token or packet");
  a_foreign_quiet: assert property (
    tok_stb && !tok_addr_ok |=> !resp_stb_q && ep_int_q == 5'h00)
    else $error("foreign token answered");
  a_bad_ep_quiet: assert property (
    tok_stb && tok_ep > 3'h4 |=> !resp_stb_q)
    else $error("token to absent endpoint answered");
  a_timeout_no_int: assert property (
    hs_timeout_stb |=> ep_int_q == 5'h00)
    else $error("interrupt after unacked data");
  a_host_ack_int: assert property (
    s_in_sent ##[1:20] s_host_ack |=> ep_int_q == (5'h01 << last_ep_q))
    else $error("no interrupt after host ack");
  a_refuse_int: assert property (
    resp_stb_q && resp_code_q inside {`UEM_R_NAK, `UEM_R_STALL}
    |-> ep_int_q == (5'h01 << last_ep_q))
    else $error("nak or stall without interrupt");
  a_ack_int_now: assert property (
    resp_stb_q && resp_code_q == `UEM_R_ACK |-> ep_int_q == (5'h01 << last_ep_q))
    else $error("ack without interrupt");
  a_tx_no_int: assert property (
    s_in_sent |-> ep_int_q == 5'h00)
    else $error("interrupt before host ack");
  a_int_one_shot: assert property (
    ep_int_q != 5'h00 |=> ep_int_q == 5'h00)
    else $error("interrupt longer than one cycle");
endmodule // uem_checker
bind uem_endpoint_engine uem_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_rdata_q(cpu_rdata_q), .tok_stb(tok_stb), .tok_pid(tok_pid),
  .tok_ep(tok_ep), .tok_addr_ok(tok_addr_ok), .pkt_stb(pkt_stb),
  .pkt_count(pkt_count), .pkt_toggle(pkt_toggle), .pkt_crc_ok(pkt_crc_ok),
  .pkt_err_ok(pkt_err_ok), .hs_ack_stb(hs_ack_stb),
  .hs_timeout_stb(hs_timeout_stb), .resp_stb_q(resp_stb_q),
  .resp_code_q(resp_code_q), .resp_count_q(resp_count_q),
  .resp_toggle_q(resp_toggle_q), .ep_int_q(ep_int_q));
`default_nettype wire

// File: dv/test_usb_endpoint_mode_count_logic.sv
`include "uem_map.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_usb_endpoint_mode_count_logic;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       cpu_wr = 1'b0;
  logic       cpu_rd = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata_q;
  wire        tok_stb, tok_addr_ok, pkt_stb, pkt_toggle, pkt_crc_ok;
  wire        pkt_err_ok, hs_ack_stb, hs_timeout_stb;
  wire  [1:0] tok_pid;
  wire  [2:0] tok_ep;
  wire  [5:0] pkt_count;
  logic       resp_stb_q, resp_toggle_q;
  logic [2:0] resp_code_q;
  logic [5:0] resp_count_q;
  logic [4:0] ep_int_q;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cyc = 0;

  always #10 core_clk = ~core_clk;

  uem_endpoint_engine DUT (
    .core_clk(core_clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata_q(cpu_rdata_q), .tok_stb(tok_stb), .tok_pid(tok_pid),
    .tok_ep(tok_ep), .tok_addr_ok(tok_addr_ok), .pkt_stb(pkt_stb),
    .pkt_count(pkt_count), .pkt_toggle(pkt_toggle), .pkt_crc_ok(pkt_crc_ok),
    .pkt_err_ok(pkt_err_ok), .hs_ack_stb(hs_ack_stb),
    .hs_timeout_stb(hs_timeout_stb), .resp_stb_q(resp_stb_q),
    .resp_code_q(resp_code_q), .resp_count_q(resp_count_q),
    .resp_toggle_q(resp_toggle_q), .ep_int_q(ep_int_q));

  uem_host_model host (
    .core_clk(core_clk), .tok_stb(tok_stb), .tok_pid(tok_pid),
    .tok_ep(tok_ep), .tok_addr_ok(tok_addr_ok), .pkt_stb(pkt_stb),
    .pkt_count(pkt_count), .pkt_toggle(pkt_toggle), .pkt_crc_ok(pkt_crc_ok),
    .pkt_err_ok(pkt_err_ok), .hs_ack_stb(hs_ack_stb),
    .hs_timeout_stb(hs_timeout_stb));

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A gap cycle after each write keeps the strobe from being set twice.
  task wr(input logic [7:0] a, input logic [7:0] d);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    @(negedge core_clk);
    `CHK("rdata", e, cpu_rdata_q)
    @(posedge core_clk);
  endtask

  // Code 7 means the response strobe is not judged.
  task step(input logic s, input logic [2:0] c, input logic [4:0] i);
    @(negedge core_clk);
    if (c != 3'h7) begin
      `CHK("resp", s, resp_stb_q)
      if (s) `CHK("code", c, resp_code_q)
    end
    `CHK("int", i, ep_int_q)
    @(posedge core_clk);
  endtask

  task t_reset;
    logic [7:0] map [11] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                             8'h41, 8'h42, 8'h43, 8'h44, 8'h20};
    foreach (map[k]) rd(map[k], 8'h00);
    host.token(`UEM_PID_OUT, 3'h1, 1'b1);
    step(1'b0, 3'h0, 5'h00);
    host.packet(6'h02, 1'b0, 1'b1);
    step(1'b0, 3'h0, 5'h00);
    $display("t_reset done");
  endtask

  task t_setup;
    wr(8'h12, 8'h0b);
    host.token(`UEM_PID_SETUP, 3'h0, 1'b1);
    rd(8'h12, 8'h8b);
    host.packet(6'h0a, 1'b0, 1'b1);
    step(1'b1, `UEM_R_ACK, 5'h01);
    wr(8'h11, 8'h05);
    wr(8'h12, 8'h8c);
    rd(8'h12, 8'h91);
    rd(8'h11, 8'h4a);
    wr(8'h12, 8'h0a);
    wr(8'h11, 8'h05);
    rd(8'h12, 8'h0a);
    rd(8'h11, 8'h05);
    host.token(`UEM_PID_OUT, 3'h0, 1'b1);
    host.packet(6'h0c, 1'b0, 1'b1);
    step(1'b0, 3'h0, 5'h00);
    host.token(`UEM_PID_IN, 3'h0, 1'b1);
    step(1'b1, `UEM_R_TXDATA, 5'h00);
    `CHK("txcount", 6'h00, resp_count_q)
    host.hs(1'b1);
    step(1'b0, 3'h0, 5'h01);
    rd(8'h12, 8'h5a);
    $display("t_setup done");
  endtask

  task t_out;
    wr(8'h14, 8'h09);
    host.token(`UEM_PID_OUT, 3'h1, 1'b1);
    host.packet(6'h22, 1'b1, 1'b1);
    step(1'b1, `UEM_R_ACK, 5'h02);
    rd(8'h13, 8'he2);
    rd(8'h14, 8'h18);
    wr(8'h14, 8'h09);
    host.token(`UEM_PID_OUT, 3'h1, 1'b1);
    host.packet(6'h04, 1'b0, 1'b0);
    step(1'b0, 3'h7, 5'h02);
    rd(8'h13, 8'h04);
    wr(8'h14, 8'h8d);
    host.token(`UEM_PID_OUT, 3'h1, 1'b1);
    host.packet(6'h04, 1'b0, 1'b1);
    step(1'b1, `UEM_R_STALL, 5'h02);
    wr(8'h14, 8'h0d);
    host.token(`UEM_PID_OUT, 3'h1, 1'b1);
    host.packet(6'h04, 1'b0, 1'b1);
    step(1'b0, 3'h0, 5'h00);
    $display("t_out done");
  endtask

  task t_in;
    logic [3:0] md [5] = '{4'h1, 4'h3, 4'h4, 4'h8, 4'hc};
    logic [2:0] rc [5] = '{3'h2, 3'h3, 3'h0, 3'h0, 3'h2};
    wr(8'h15, 8'h83);
    wr(8'h16, 8'h0d);
    host.token(`UEM_PID_IN, 3'h2, 1'b1);
    step(1'b1, `UEM_R_TXDATA, 5'h00);
    `CHK("txcount", 6'h03, resp_count_q)
    `CHK("txtoggle", 1'b1, resp_toggle_q)
    host.hs(1'b1);
    step(1'b0, 3'h0, 5'h04);
    rd(8'h16, 8'h1c);
    wr(8'h16, 8'h0d);
    host.token(`UEM_PID_IN, 3'h2, 1'b1);
    step(1'b1, `UEM_R_TXDATA, 5'h00);
    host.hs(1'b0);
    step(1'b0, 3'h0, 5'h00);
    rd(8'h16, 8'h0d);
    host.token(`UEM_PID_IN, 3'h2, 1'b0);
    step(1'b0, 3'h0, 5'h00);
    host.token(`UEM_PID_IN, 3'h5, 1'b1);
    step(1'b0, 3'h0, 5'h00);
    for (int k = 0; k < 5; k++) begin
      wr(8'h42, {4'h0, md[k]});
      host.token(`UEM_PID_IN, 3'h3, 1'b1);
      step(rc[k] != 3'h0, rc[k], (rc[k] != 3'h0) ? 5'h08 : 5'h00);
    end
    $display("t_in done");
  endtask

  // Whole run needs about 130 cycles; the ceiling leaves ample room.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_setup;
    t_out;
    t_in;
    report_and_stop;
  end
endmodule // test_usb_endpoint_mode_count_logic
`default_nettype wire
